//--- shared/udl_map.svh
// Purpose: offsets, field positions, reset values and the clock period
// Assumes: byte-wide register port, 20 MHz system clock
// Notes:   definitions only
`ifndef UDL_MAP_SVH
`define UDL_MAP_SVH

// ============================================================
// register offsets
`define UDL_DLDC_ADDR       8'h36
`define UDL_FREQ_CFG_ADDR   8'h01

// ============================================================
// field positions
`define UDL_DPLUS_MSB       7
`define UDL_DPLUS_LSB       5
`define UDL_DMINUS_MSB      4
`define UDL_DMINUS_LSB      2
`define UDL_HVSE_BIT        1
`define UDL_FSW_MSB         2
`define UDL_FSW_LSB         0

// ============================================================
// reset values and level codes
`define UDL_DLDC_RESET      8'h00
`define UDL_FSW_RESET       3'h2
`define UDL_CODE_HIZ        3'h0
`define UDL_CODE_RSVD       3'h7

// ============================================================
// timing: 50 ns clock
`define UDL_CLK_PERIOD_NS   50

`endif

//--- shared/udl_pkg.sv
// Purpose: types shared by the data-line driver control block
// Assumes: udl_map.svh holds all numeric constants
// Notes:   level code enumeration follows the pin driver encoding
package udl_pkg;

  // ============================================================
  // level codes
  typedef enum logic [2:0] {
    UDL_LVL_HIZ  = 3'h0,
    UDL_LVL_0V0  = 3'h1,
    UDL_LVL_0V6  = 3'h2,
    UDL_LVL_1V2  = 3'h3,
    UDL_LVL_2V0  = 3'h4,
    UDL_LVL_2V7  = 3'h5,
    UDL_LVL_3V3  = 3'h6,
    UDL_LVL_RSVD = 3'h7
  } udl_level_t;

  // ============================================================
  // write-side state
  typedef enum logic [1:0] {
    UDL_ST_LOCKED = 2'b00,
    UDL_ST_OPEN   = 2'b01
  } udl_state_t;

endpackage

//--- src/udl_dline_ctrl.sv
// Purpose: data-line driver control register and frequency setting
// Assumes: byte register port on the system clock, insert and
//          detection-done inputs come from pins or analog blocks
// Notes:   plug-in clears the level fields; level writes are dropped until detection is done
`include "udl_map.svh"

// How it works
// - d-plus driver follows code in bits 7..5, 000 high impedance.
// - d-minus driver follows code in bits 4..2, same encoding.
// - source plug-in returns both level fields to high impedance.
// - bit 1 enables the high-voltage signalling, default off.
// - switching frequency select defaults to 500 kHz, 3-bit field.
module udl_dline_ctrl
  import udl_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // system events
  input  wire logic       soft_reg_reset,
  input  wire logic       watchdog_expired,
  input  wire logic       source_present,
  input  wire logic       detection_done,
  // pin drivers
  output logic            dplus_drive_enable,
  output logic [2:0]      dplus_drive_select,
  output logic            dminus_drive_enable,
  output logic [2:0]      dminus_drive_select,
  output logic            high_voltage_signalling_enable,
  output logic [2:0]      switching_frequency_select
);
  import udl_pkg::*;

  typedef struct packed {
    logic [2:0] dplus_level_code;
    logic [2:0] dminus_level_code;
    logic       hvse;
    logic [2:0] fsw;
    logic [7:0] rdata;
    logic [1:0] present_sync;
    logic [1:0] done_sync;
    logic       present_seen;
    udl_state_t state;
  } udl_st_t;

  udl_st_t st_reg;
  udl_st_t st_next;

  logic plug_in;
  logic wr_dldc;
  logic wr_freq;
  logic rd_dldc;
  logic rd_freq;
  logic levels_open;

  // ============================================================
  // helpers
  // offset match, shared by the write and the read strobes
  function automatic logic udl_is_dldc(input logic [7:0] addr);
    udl_is_dldc = (addr == `UDL_DLDC_ADDR);
  endfunction

  function automatic logic udl_is_freq(input logic [7:0] addr);
    udl_is_freq = (addr == `UDL_FREQ_CFG_ADDR);
  endfunction

  // three-bit field of a written byte, placed by its lsb
  function automatic logic [2:0] udl_field3(input logic [7:0] d,
                                            input int unsigned lsb);
    udl_field3 = 3'(d >> lsb);
  endfunction

  // both level fields back to high impedance, the rest untouched
  function automatic udl_st_t udl_clear_levels(input udl_st_t s);
    udl_st_t r;
    r                   = s;
    r.dplus_level_code  = `UDL_CODE_HIZ;
    r.dminus_level_code = `UDL_CODE_HIZ;
    udl_clear_levels    = r;
  endfunction

  // read image of the driver control byte, bit 0 stays zero
  function automatic logic [7:0] udl_pack(input udl_st_t s);
    logic [7:0] r;
    r                                  = `UDL_DLDC_RESET;
    r[`UDL_DPLUS_MSB:`UDL_DPLUS_LSB]   = s.dplus_level_code;
    r[`UDL_DMINUS_MSB:`UDL_DMINUS_LSB] = s.dminus_level_code;
    r[`UDL_HVSE_BIT]                   = s.hvse;
    udl_pack                           = r;
  endfunction

  // read image of the frequency byte, unused bits read zero
  function automatic logic [7:0] udl_pack_freq(input udl_st_t s);
    logic [7:0] r;
    r                            = 8'h00;
    r[`UDL_FSW_MSB:`UDL_FSW_LSB] = s.fsw;
    udl_pack_freq                = r;
  endfunction

  // ============================================================
  // strobes
  // plug-in is the rising edge of the synchronised presence
  assign plug_in     = st_reg.present_sync[1] & ~st_reg.present_seen;
  assign wr_dldc     = reg_wr && udl_is_dldc(reg_addr);
  assign wr_freq     = reg_wr && udl_is_freq(reg_addr);
  assign rd_dldc     = reg_rd && udl_is_dldc(reg_addr);
  assign rd_freq     = reg_rd && udl_is_freq(reg_addr);
  assign levels_open = (st_reg.state == UDL_ST_OPEN);

  // ============================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.present_sync = {st_reg.present_sync[0], source_present};
    st_next.done_sync    = {st_reg.done_sync[0], detection_done};
    st_next.present_seen = st_reg.present_sync[1];

    // level writes only land once detection has finished
    case (st_reg.state)
      UDL_ST_LOCKED: begin
        if (st_reg.done_sync[1] && !plug_in) begin
          st_next.state = UDL_ST_OPEN;
        end
      end
      UDL_ST_OPEN: begin
        if (plug_in || !st_reg.present_sync[1]) begin
          st_next.state = UDL_ST_LOCKED;
        end
      end
      default: st_next.state = UDL_ST_LOCKED;
    endcase

    // ============================================================
    // register writes
    // the enable stays writable while the level fields are locked
    if (wr_dldc) begin
      if (levels_open) begin
        st_next.dplus_level_code  =
          udl_field3(reg_wdata, `UDL_DPLUS_LSB);
        st_next.dminus_level_code =
          udl_field3(reg_wdata, `UDL_DMINUS_LSB);
      end
      st_next.hvse = reg_wdata[`UDL_HVSE_BIT];
    end
    if (wr_freq) begin
      st_next.fsw = udl_field3(reg_wdata, `UDL_FSW_LSB);
    end

    // ============================================================
    // clears
    // plug-in beats a same-cycle write
    if (plug_in) begin
      st_next = udl_clear_levels(st_next);
    end
    if (soft_reg_reset || watchdog_expired) begin
      st_next      = udl_clear_levels(st_next);
      st_next.hvse = 1'b0;
    end
    if (soft_reg_reset) begin
      // watchdog leaves the frequency alone
      st_next.fsw = `UDL_FSW_RESET;
    end

    // ============================================================
    // read data
    // registered one cycle after the strobe, held until the next read
    if (rd_dldc) begin
      st_next.rdata = udl_pack(st_reg);
    end else if (rd_freq) begin
      st_next.rdata = udl_pack_freq(st_reg);
    end else if (reg_rd) begin
      // unmapped offsets read as zero
      st_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.fsw   <= `UDL_FSW_RESET;
      st_reg.state <= UDL_ST_LOCKED;
    end else begin
      st_reg <= st_next;
    end
  end

  // ============================================================
  // elaboration checks
  // the logic packs three-bit level and frequency fields into a byte
  if ((`UDL_DPLUS_MSB - `UDL_DPLUS_LSB) != 2 ||
      (`UDL_DMINUS_MSB - `UDL_DMINUS_LSB) != 2 ||
      (`UDL_FSW_MSB - `UDL_FSW_LSB) != 2) begin : g_bad_width
    $error("level and frequency fields must be three bits wide");
  end
  // fields may not overlap, bit 0 stays reserved
  if (`UDL_DPLUS_MSB > 7 ||
      `UDL_DPLUS_LSB <= `UDL_DMINUS_MSB ||
      `UDL_DMINUS_LSB <= `UDL_HVSE_BIT ||
      `UDL_HVSE_BIT < 1 || `UDL_FSW_MSB > 7) begin : g_bad_layout
    $error("driver control fields overlap or leave the byte");
  end

  // ============================================================
  // pin drivers
  udl_level_decoder u_dplus (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .level_code   (st_reg.dplus_level_code),
    .drive_enable (dplus_drive_enable),
    .drive_select (dplus_drive_select)
  );

  udl_level_decoder u_dminus (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .level_code   (st_reg.dminus_level_code),
    .drive_enable (dminus_drive_enable),
    .drive_select (dminus_drive_select)
  );

  assign reg_rdata                      = st_reg.rdata;
  assign high_voltage_signalling_enable = st_reg.hvse;
  assign switching_frequency_select     = st_reg.fsw;

endmodule

//--- src/udl_level_decoder.sv
// Purpose: turn one 3-bit level code into pin driver controls
// Assumes: code comes from a register on the same clock
// Notes:   reserved code is held as high impedance for safety
module udl_level_decoder
  import udl_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // code in
  input  wire logic [2:0] level_code,
  // driver out
  output logic            drive_enable,
  output logic [2:0]      drive_select
);

  typedef struct packed {
    logic       en;
    logic [2:0] sel;
  } udl_dec_t;

  udl_dec_t st_reg;
  udl_dec_t st_next;

  // ============================================================
  // decode
  always_comb begin
    st_next = st_reg;
    case (udl_level_t'(level_code))
      UDL_LVL_HIZ, UDL_LVL_RSVD: begin
        // reserved code defines no level, so keep the pin released
        st_next.en  = 1'b0;
        st_next.sel = 3'h0;
      end
      default: begin
        st_next.en  = 1'b1;
        st_next.sel = level_code - 3'h1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign drive_enable = st_reg.en;
  assign drive_select = st_reg.sel;

endmodule

//--- testbench/udl_adapter_model.sv
// Purpose: charging adapter on the data lines
// Assumes: plug comes from the bench
// Notes:   detection length is a plain parameter
module udl_adapter_model #(parameter int DET_CYCLES = 8) (
  input wire logic clock, plug,
  output logic     source_present, detection_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  assign source_present = plug;
  // detection restarts on every attach
  always @(posedge clock) cnt <= plug ? cnt + int'(cnt < DET_CYCLES) : 0;
  assign detection_done = plug && cnt >= DET_CYCLES;
endmodule

//--- testbench/udl_dline_props.sv
// Purpose: port checker for the data-line driver control block
// Assumes: bound to udl_dline_ctrl, bench never writes code 111
// Notes:   register value is seen through reads of 0x36
module udl_dline_props (
  input wire logic       clock, sys_rst, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       soft_reg_reset, watchdog_expired, source_present,
  input wire logic       dplus_drive_enable, dminus_drive_enable,
  input wire logic       high_voltage_signalling_enable,
  input wire logic [2:0] dplus_drive_select, dminus_drive_select,
  input wire logic [2:0] switching_frequency_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ====================
  // read of 0x36 launched last edge
  logic rd36_q;
  always_ff @(posedge clock) rd36_q <= reg_rd && (reg_addr == 8'h36);
  // drive lags register one edge, read data too: both show one value
  property p_dp_read;
    rd36_q |-> dplus_drive_enable == (reg_rdata[7:5] != 3'h0) &&
      (!dplus_drive_enable || dplus_drive_select == reg_rdata[7:5] - 3'h1);
  endproperty
  a_dp_read: assert property (p_dp_read) else $error("d-plus drive");
  property p_dm_read;
    rd36_q |-> dminus_drive_enable == (reg_rdata[4:2] != 3'h0) &&
      (!dminus_drive_enable || dminus_drive_select == reg_rdata[4:2] - 3'h1);
  endproperty
  a_dm_read: assert property (p_dm_read) else $error("d-minus drive");
  property p_bit0;
    rd36_q |-> !reg_rdata[0];
  endproperty
  a_bit0: assert property (p_bit0) else $error("bit 0 not zero");
  property p_wd_clr;
    watchdog_expired && !reg_wr |-> ##[1:2] !high_voltage_signalling_enable;
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("watchdog keep");
  property p_hv_wr;
    reg_wr && reg_addr == 8'h36 && !watchdog_expired && !soft_reg_reset
      |=> high_voltage_signalling_enable == $past(reg_wdata[1]);
  endproperty
  a_hv_wr: assert property (p_hv_wr) else $error("enable write");
  property p_fsw_soft;
    soft_reg_reset |-> ##[1:2] switching_frequency_select == 3'h2;
  endproperty
  a_fsw_soft: assert property (p_fsw_soft) else $error("fsw reset");
  property p_fsw_wr;
    reg_wr && reg_addr == 8'h01 && !soft_reg_reset
      |=> switching_frequency_select == $past(reg_wdata[2:0]);
  endproperty
  a_fsw_wr: assert property (p_fsw_wr) else $error("fsw write");
  // plug-in locks the fields, so no write can refill them meanwhile
  property p_plug;
    $rose(source_present) |-> ##[5:7]
      !dplus_drive_enable && !dminus_drive_enable;
  endproperty
  a_plug: assert property (p_plug) else $error("plug clear");
  c_drive: cover property (rd36_q && dplus_drive_enable);
  c_plug: cover property ($rose(source_present));
  c_wd: cover property (watchdog_expired);
endmodule
bind udl_dline_ctrl udl_dline_props chk (.*);

//--- testbench/usb_data_line_dac_control_bench.sv
// Purpose: self-checking bench for the driver control block
// Assumes: inputs change at the falling edge
// Notes:   random codes never reserved
module usb_data_line_dac_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, plug = 0;
  logic soft_reg_reset = 0, watchdog_expired = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
  logic source_present, detection_done, dpe, dme, hve;
  logic [2:0] dps, dms, fsw, c1, c2;
  logic [31:0] seed = 32'd30;
  int bad_count = 0, num_checks = 0;
  initial forever #25 clock = ~clock;
  udl_dline_ctrl uut (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .soft_reg_reset, .watchdog_expired,
    .source_present, .detection_done, .dplus_drive_enable(dpe),
    .dplus_drive_select(dps), .dminus_drive_enable(dme),
    .dminus_drive_select(dms), .high_voltage_signalling_enable(hve),
    .switching_frequency_select(fsw));
  udl_adapter_model adapter (.clock, .plug, .source_present,
    .detection_done);
  // ====================
  function automatic logic [3:0] drv(logic [2:0] c);
    return (c == 3'h0) ? 4'h0 : {1'b1, c - 3'h1};
  endfunction
  function automatic logic [31:0] xorshift(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge clock);
    reg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clock);
    reg_rd = 1; reg_addr = a;
    @(negedge clock);
    reg_rd = 0;
    chk("rdata", e, reg_rdata);
  endtask
  task automatic pins(logic [7:0] x);
    @(negedge clock);
    chk("dplus", {4'h0, drv(x[7:5])}, {4'h0, dpe, dpe ? dps : 3'h0});
    chk("dminus", {4'h0, drv(x[4:2])}, {4'h0, dme, dme ? dms : 3'h0});
    chk("hvse", {7'h0, x[1]}, {7'h0, hve});
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ====================
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 0;
    rd(8'h36, 8'h00);
    rd(8'h01, 8'h02);
    chk("fsw", 8'h02, {5'h00, fsw});
    rd(8'h55, 8'h00);
    wr(8'h36, 8'hc3);
    rd(8'h36, 8'h02);
    plug = 1;
    wait (detection_done);
    repeat (6) @(negedge clock);
    for (int i = 0; i < 7; i++) begin
      v = {i[2:0], 3'(6 - i), 2'b10};
      wr(8'h36, v);
      pins(v);
    end
    repeat (20) begin
      seed = xorshift(seed);
      c1 = (seed[7:5] == 3'h7) ? 3'h0 : seed[7:5];
      c2 = (seed[4:2] == 3'h7) ? 3'h0 : seed[4:2];
      wr(8'h36, {c1, c2, seed[1:0]});
      rd(8'h36, {c1, c2, seed[1], 1'b0});
      pins({c1, c2, seed[1], 1'b0});
    end
    wr(8'h01, 8'h05);
    @(negedge clock) watchdog_expired = 1;
    @(negedge clock) watchdog_expired = 0;
    rd(8'h36, 8'h00);
    rd(8'h01, 8'h05);
    chk("fsw", 8'h05, {5'h00, fsw});
    wr(8'h36, 8'h8a);
    @(negedge clock) soft_reg_reset = 1;
    @(negedge clock) soft_reg_reset = 0;
    rd(8'h36, 8'h00);
    rd(8'h01, 8'h02);
    chk("fsw", 8'h02, {5'h00, fsw});
    wr(8'h36, 8'h6a);
    plug = 0;
    repeat (4) @(negedge clock);
    plug = 1;
    repeat (8) @(negedge clock);
    rd(8'h36, 8'h02);
    pins(8'h02);
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule
